//--- hdl/odp_flash.sv
// Flash end: one-time array access and deep power-down command handling.
// Notes on behaviour
// - Host sends read opcode, address, dummy cycles.
// - Address sampled rising, data out falling edge.
// - Read address advances, sticks at 0x40.
// - Chip select high ends read, output released.
// - Program without write enable: ignored silently.
// - Host sends opcode, address, data, then deselects.
// - Programming starts only on chip select rise.
// - At most 65 bytes kept, rest discarded.
// - Busy bit high during programming, then low.
// - Write enable cleared when a program completes or times out.
// - Timeout clears write enable, sets fail.
// - No deselect means no program, latch kept.
// - Flag bit 7 shows ready for polling.
// - Control bit 0 low locks array forever.
// - Locked array: ignore, keep latch, set 1,4.
// - B9h then deselect enters power-down after delay.
// - Power-down refused while write in progress.
// - Power-down ignores all but release and resets.
// - ABh releases; extra clocks void it.
// - Host keeps deselected during exit delay.
// - Resets also leave power-down after recovery.
module odp_flash
    import odp_pkg::*;
#(
    parameter int PROG_CYC = POTP_CYC,
    parameter int PROG_TIMEOUT = POTP_TIMEOUT_CYC,
    parameter int DP_DELAY = DP_CYC,
    parameter int RDP_DELAY = RDP_CYC,
    parameter int RST_DELAY = RST_REC_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic hw_reset_n,
    input wire logic prog_stall,
    odp_spi_if.flash spi,
    output logic powered_down,
    output logic low_current,
    output logic busy
);
    typedef enum {ST_IDLE, ST_PROG, ST_DPD_ENTER, ST_DPD, ST_EXIT} odp_st_e;
    logic [2:0] cs_sync_ff, sck_sync_ff, din_sync_ff;
    logic [7:0] otp_ff [0:OTP_BYTES];
    logic [7:0] shift_ff;
    logic [2:0] bit_cnt_ff;
    logic [5:0] byte_cnt_ff;
    logic [7:0] op_ff;
    logic [23:0] addr_ff;
    logic [6:0] ptr_ff;
    logic [6:0] prog_cnt_ff;
    logic [7:0] pbuf_ff [0:OTP_BYTES];
    logic [64:0] pvalid_ff;
    logic [6:0] prog_base_ff;
    logic [7:0] dummy_ff;
    logic extra_ff;
    logic wel_ff, fail_ff, prot_ff, rst_en_ff;
    logic [31:0] timer_ff;
    odp_st_e st_ff;
    logic dout_ff, doe_ff;
    logic [7:0] out_byte_ff;
    logic pd_ff, lc_ff, busy_ff;
    wire cs_n = cs_sync_ff[1];
    wire cs_rise = cs_sync_ff[1] & ~cs_sync_ff[2];
    wire sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2] & ~cs_n;
    wire sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2] & ~cs_n;
    wire din = din_sync_ff[1];
    wire [7:0] shifted = {shift_ff[6:0], din};
    wire byte_done = sck_rise && bit_cnt_ff == 3'd7;
    wire wip = st_ff == ST_PROG;
    wire in_dpd = st_ff == ST_DPD || st_ff == ST_DPD_ENTER;
    wire locked = ~otp_ff[OTP_CTRL_ADDR][0];
    wire [7:0] flag_val = {~wip, 2'h0, fail_ff, 2'h0, prot_ff, 1'b0};
    wire [7:0] stat_val = {6'h0, wel_ff, wip};
    wire is_read = op_ff == OP_READ_OTP;
    wire is_prog = op_ff == OP_PROG_OTP;
    wire addr_phase = byte_cnt_ff >= 6'd1 && byte_cnt_ff <= 6'd3;
    wire data_phase = byte_cnt_ff >= 6'd4;
    wire [6:0] rd_ptr_next = ptr_ff == OTP_CTRL_ADDR ? ptr_ff : ptr_ff + 7'd1;
    // The third address byte is still on the shifter when this is used.
    wire [23:0] addr_in = {addr_ff[15:0], shifted};
    wire [6:0] start_ptr = addr_in > 24'(OTP_CTRL_ADDR) ? OTP_CTRL_ADDR
        : addr_in[6:0];
    wire prog_ok = is_prog && byte_cnt_ff >= 6'd4 && bit_cnt_ff == 3'd0
        && prog_cnt_ff != 7'd0;
    wire timer_done = timer_ff == 32'd0;
    assign spi.serial_output_line = dout_ff;
    assign spi.serial_output_line_oe = doe_ff;
    assign powered_down = pd_ff;
    assign low_current = lc_ff;
    assign busy = busy_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_sync_ff <= 3'h7;
            sck_sync_ff <= 3'h0;
            din_sync_ff <= 3'h0;
        end else if (clk_en) begin
            cs_sync_ff <= {cs_sync_ff[1:0], spi.cs_n};
            sck_sync_ff <= {sck_sync_ff[1:0], spi.sck};
            din_sync_ff <= {din_sync_ff[1:0], spi.serial_input_line};
        end
    end

    // Command framing; a byte counter saturates so long bursts stay bounded.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_ff <= 8'h0;
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 6'h0;
            op_ff <= 8'h0;
            addr_ff <= 24'h0;
            dummy_ff <= 8'h0;
            extra_ff <= 1'b0;
        end else if (clk_en) begin
            if (cs_n) begin
                bit_cnt_ff <= 3'h0;
                byte_cnt_ff <= 6'h0;
                extra_ff <= 1'b0;
                dummy_ff <= 8'h0;
            end else if (sck_rise) begin
                shift_ff <= shifted;
                bit_cnt_ff <= bit_cnt_ff + 3'd1;
                if (byte_cnt_ff != 6'd0 || bit_cnt_ff != 3'd7) begin
                    extra_ff <= byte_cnt_ff != 6'd0;
                end
                if (byte_done) begin
                    if (byte_cnt_ff != 6'h3f) begin
                        byte_cnt_ff <= byte_cnt_ff + 6'd1;
                    end
                    if (byte_cnt_ff == 6'd0) begin
                        op_ff <= shifted;
                    end else if (addr_phase) begin
                        addr_ff <= {addr_ff[15:0], shifted};
                    end
                end
                if (is_read && data_phase && dummy_ff != 8'(DUMMY_CYCLES)) begin
                    dummy_ff <= dummy_ff + 8'd1;
                end
            end
        end
    end

    // Read path: output shifts on falling edges once dummy cycles pass.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_ff <= 7'h0;
            out_byte_ff <= 8'h0;
            dout_ff <= 1'b0;
            doe_ff <= 1'b0;
        end else if (clk_en) begin
            if (cs_n || in_dpd) begin
                doe_ff <= 1'b0;
            end else if (sck_fall && byte_cnt_ff >= 6'd4) begin
                if (is_read && dummy_ff == 8'(DUMMY_CYCLES)) begin
                    doe_ff <= 1'b1;
                    dout_ff <= out_byte_ff[7 - bit_cnt_ff];
                    if (bit_cnt_ff == 3'd7) begin
                        ptr_ff <= rd_ptr_next;
                        out_byte_ff <= otp_ff[rd_ptr_next];
                    end
                end
            end else if (sck_fall && byte_cnt_ff == 6'd1 && bit_cnt_ff == 3'd0
                    && (op_ff == OP_RD_FLAG || op_ff == OP_RD_STATUS)) begin
                doe_ff <= 1'b1;
                out_byte_ff <= op_ff == OP_RD_FLAG ? flag_val : stat_val;
                dout_ff <= op_ff == OP_RD_FLAG ? flag_val[7] : stat_val[7];
            end else if (sck_fall && byte_cnt_ff >= 6'd1
                    && (op_ff == OP_RD_FLAG || op_ff == OP_RD_STATUS)) begin
                dout_ff <= out_byte_ff[7 - bit_cnt_ff];
                if (bit_cnt_ff == 3'd7) begin
                    out_byte_ff <= op_ff == OP_RD_FLAG ? flag_val : stat_val;
                end
            end
            if (byte_done && byte_cnt_ff == 6'd3 && is_read) begin
                ptr_ff <= start_ptr;
                out_byte_ff <= otp_ff[start_ptr];
            end
        end
    end

    // Program buffer collects data bytes; the address never wraps.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prog_cnt_ff <= 7'h0;
            prog_base_ff <= 7'h0;
            pvalid_ff <= '0;
            for (int i = 0; i <= OTP_BYTES; i++) begin
                pbuf_ff[i] <= 8'h0;
            end
        end else if (clk_en) begin
            if (byte_done && byte_cnt_ff == 6'd3) begin
                prog_cnt_ff <= 7'h0;
                pvalid_ff <= '0;
                prog_base_ff <= start_ptr;
            end else if (byte_done && is_prog && data_phase) begin
                if (prog_cnt_ff != 7'(PROG_MAX_BYTES)
                        && 8'(prog_base_ff) + 8'(prog_cnt_ff) <= 8'h40) begin
                    pbuf_ff[prog_base_ff + prog_cnt_ff] <= shifted;
                    pvalid_ff[prog_base_ff + prog_cnt_ff] <= 1'b1;
                    prog_cnt_ff <= prog_cnt_ff + 7'd1;
                end
            end
        end
    end

    wire cmd_allowed = !in_dpd;
    wire wren_cmd = cs_rise && op_ff == OP_WREN && byte_cnt_ff == 6'd1
        && cmd_allowed && !wip;
    wire sw_reset = cs_rise && op_ff == OP_RST && byte_cnt_ff == 6'd1
        && rst_en_ff;
    wire any_reset = sw_reset || !hw_reset_n;

    // Device state: programming, power-down and recovery timing.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= ST_IDLE;
            timer_ff <= 32'h0;
            wel_ff <= 1'b0;
            fail_ff <= 1'b0;
            prot_ff <= 1'b0;
            rst_en_ff <= 1'b0;
            pd_ff <= 1'b0;
            lc_ff <= 1'b0;
            busy_ff <= 1'b0;
            for (int i = 0; i <= OTP_BYTES; i++) begin
                otp_ff[i] <= OTP_ERASED;
            end
        end else if (clk_en) begin
            if (timer_ff != 32'h0) begin
                timer_ff <= timer_ff - 32'd1;
            end
            if (cs_rise && byte_cnt_ff == 6'd1) begin
                rst_en_ff <= op_ff == OP_RST_EN;
            end
            if (any_reset) begin
                st_ff <= ST_EXIT;
                timer_ff <= 32'(RST_DELAY);
                wel_ff <= 1'b0;
            end else if (wren_cmd) begin
                wel_ff <= 1'b1;
            end
            if (!any_reset) begin
                case (st_ff)
                ST_IDLE: begin
                    if (cs_rise && prog_ok) begin
                        if (!wel_ff) begin
                            ;
                        end else if (locked) begin
                            prot_ff <= 1'b1;
                            fail_ff <= 1'b1;
                        end else begin
                            st_ff <= ST_PROG;
                            timer_ff <= 32'(PROG_CYC);
                        end
                    end else if (cs_rise && op_ff == OP_ENTER_DPD
                            && byte_cnt_ff == 6'd1 && !extra_ff) begin
                        st_ff <= ST_DPD_ENTER;
                        timer_ff <= 32'(DP_DELAY);
                    end
                end
                ST_PROG: begin
                    if (!prog_stall && timer_done) begin
                        st_ff <= ST_IDLE;
                        wel_ff <= 1'b0;
                        for (int i = 0; i < OTP_BYTES; i++) begin
                            if (pvalid_ff[i]) begin
                                otp_ff[i] <= otp_ff[i] & pbuf_ff[i];
                            end
                        end
                        if (pvalid_ff[OTP_BYTES]) begin
                            otp_ff[OTP_BYTES][0] <= otp_ff[OTP_BYTES][0]
                                & pbuf_ff[OTP_BYTES][0];
                        end
                    end else if (prog_stall && timer_ff == 32'h0
                            && busy_ff) begin
                        st_ff <= ST_IDLE;
                        wel_ff <= 1'b0;
                        fail_ff <= 1'b1;
                    end
                end
                ST_DPD_ENTER: begin
                    if (timer_done) begin
                        st_ff <= ST_DPD;
                    end
                end
                ST_DPD: begin
                    if (cs_rise && op_ff == OP_RELEASE_DPD
                            && byte_cnt_ff == 6'd1 && !extra_ff) begin
                        st_ff <= ST_EXIT;
                        timer_ff <= 32'(RDP_DELAY);
                    end
                end
                ST_EXIT: begin
                    if (timer_done) begin
                        st_ff <= ST_IDLE;
                    end
                end
                default: st_ff <= ST_IDLE;
                endcase
            end
            // Timeout is kept separate: a stall past the limit ends the try.
            if (st_ff == ST_PROG && !busy_ff) begin
                busy_ff <= 1'b1;
            end else if (st_ff != ST_PROG) begin
                busy_ff <= 1'b0;
            end
            if (st_ff == ST_PROG && prog_stall && !busy_ff
                    && !any_reset) begin
                timer_ff <= 32'(PROG_TIMEOUT);
            end
            pd_ff <= st_ff == ST_DPD || st_ff == ST_DPD_ENTER;
            lc_ff <= st_ff == ST_DPD;
        end
    end
endmodule

//--- hdl/odp_pkg.sv
// Package of constants shared by the flash end and the host end.
package odp_pkg;
    localparam logic [7:0] OP_READ_OTP = 8'h4b;
    localparam logic [7:0] OP_PROG_OTP = 8'h42;
    localparam logic [7:0] OP_ENTER_DPD = 8'hb9;
    localparam logic [7:0] OP_RELEASE_DPD = 8'hab;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_RD_FLAG = 8'h70;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam int ADDR_BYTES = 3;
    localparam int DUMMY_CYCLES = 8;
    localparam int OTP_BYTES = 64;
    localparam logic [6:0] OTP_CTRL_ADDR = 7'h40;
    localparam logic [7:0] OTP_CTRL_RESET = 8'hff;
    localparam int PROG_MAX_BYTES = 65;
    localparam logic [7:0] OTP_ERASED = 8'hff;
    localparam int FLAG_READY_BIT = 7;
    localparam int FLAG_PROG_FAIL_BIT = 4;
    localparam int FLAG_PROTECT_BIT = 1;
    localparam int STAT_WIP_BIT = 0;
    localparam int STAT_WEL_BIT = 1;
    localparam int CLK_MHZ = 100;
    localparam int POTP_NS = 2000;
    localparam int POTP_CYC = (POTP_NS * CLK_MHZ) / 1000;
    localparam int POTP_TIMEOUT_CYC = 4 * POTP_CYC;
    localparam int DP_NS = 3000;
    localparam int DP_CYC = (DP_NS * CLK_MHZ) / 1000;
    localparam int RDP_NS = 30000;
    localparam int RDP_CYC = (RDP_NS * CLK_MHZ) / 1000;
    localparam int RST_REC_NS = 40000;
    localparam int RST_REC_CYC = (RST_REC_NS * CLK_MHZ) / 1000;
    localparam int SCK_HALF_CYC = 4;
endpackage

//--- hdl/odp_spi_if.sv
// Serial link between the host controller and the flash end.
interface odp_spi_if;
    logic cs_n;
    logic sck;
    logic serial_input_line;
    logic serial_output_line;
    logic serial_output_line_oe;
    logic line_level;
    assign line_level = serial_output_line_oe ? serial_output_line : 1'b1;
    modport flash (input cs_n, input sck, input serial_input_line,
        output serial_output_line, output serial_output_line_oe);
    modport host (output cs_n, output sck, output serial_input_line,
        input line_level);
endinterface

//--- hdl/odp_host.sv
// Host end: issues one framed command at a time over the serial link.
module odp_host
    import odp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic req,
    input wire logic [7:0] opcode,
    input wire logic [5:0] tx_len,
    input wire logic [5:0] rx_len,
    input wire logic [7:0] tx_data,
    odp_spi_if.host spi,
    output logic tx_take,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic done,
    output logic idle
);
    typedef enum {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP} odp_hst_e;
    odp_hst_e st_ff;
    logic [2:0] in_sync_ff;
    logic cs_n_ff, sck_ff, mosi_ff;
    logic [7:0] sh_ff, rx_ff, rxd_ff;
    logic [2:0] bit_ff;
    logic [6:0] bytes_ff;
    logic [6:0] total_ff;
    logic [5:0] rxn_ff;
    logic [2:0] div_ff;
    logic take_ff, rv_ff, done_ff, idle_ff;
    wire half = div_ff == 3'(SCK_HALF_CYC - 1);
    wire last_bit = bit_ff == 3'd7;
    wire last_byte = bytes_ff == total_ff - 7'd1;
    wire in_rx = bytes_ff > 7'(tx_len);
    assign spi.cs_n = cs_n_ff;
    assign spi.sck = sck_ff;
    assign spi.serial_input_line = mosi_ff;
    assign tx_take = take_ff;
    assign rx_valid = rv_ff;
    assign rx_data = rxd_ff;
    assign done = done_ff;
    assign idle = idle_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_sync_ff <= 3'h0;
        end else if (clk_en) begin
            in_sync_ff <= {in_sync_ff[1:0], spi.line_level};
        end
    end

    // Chip select is raised only on a byte boundary, after the eighth bit.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= HS_IDLE;
            cs_n_ff <= 1'b1;
            sck_ff <= 1'b0;
            mosi_ff <= 1'b0;
            sh_ff <= 8'h0;
            rx_ff <= 8'h0;
            rxd_ff <= 8'h0;
            bit_ff <= 3'h0;
            bytes_ff <= 7'h0;
            total_ff <= 7'h0;
            rxn_ff <= 6'h0;
            div_ff <= 3'h0;
            take_ff <= 1'b0;
            rv_ff <= 1'b0;
            done_ff <= 1'b0;
            idle_ff <= 1'b1;
        end else if (clk_en) begin
            take_ff <= 1'b0;
            rv_ff <= 1'b0;
            done_ff <= 1'b0;
            div_ff <= half ? 3'h0 : div_ff + 3'd1;
            case (st_ff)
            HS_IDLE: begin
                div_ff <= 3'h0;
                if (req) begin
                    st_ff <= HS_LOW;
                    idle_ff <= 1'b0;
                    cs_n_ff <= 1'b0;
                    sh_ff <= opcode;
                    mosi_ff <= opcode[7];
                    bit_ff <= 3'h0;
                    bytes_ff <= 7'h0;
                    total_ff <= 7'd1 + 7'(tx_len) + 7'(rx_len);
                    rxn_ff <= rx_len;
                end
            end
            HS_LOW: begin
                if (half) begin
                    sck_ff <= 1'b1;
                    st_ff <= HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (half) begin
                    sck_ff <= 1'b0;
                    // The round trip through both synchronisers outlasts a
                    // half period, so the returned bit is taken on the fall.
                    rx_ff <= {rx_ff[6:0], in_sync_ff[2]};
                    bit_ff <= bit_ff + 3'd1;
                    sh_ff <= {sh_ff[6:0], 1'b0};
                    mosi_ff <= sh_ff[6];
                    st_ff <= HS_LOW;
                    if (last_bit) begin
                        if (in_rx) begin
                            rv_ff <= 1'b1;
                            rxd_ff <= {rx_ff[6:0], in_sync_ff[2]};
                        end
                        bytes_ff <= bytes_ff + 7'd1;
                        if (last_byte) begin
                            cs_n_ff <= 1'b1;
                            st_ff <= HS_GAP;
                        end else if (bytes_ff < 7'(tx_len)) begin
                            take_ff <= 1'b1;
                            sh_ff <= tx_data;
                            mosi_ff <= tx_data[7];
                        end
                    end
                end
            end
            HS_GAP: begin
                if (half) begin
                    st_ff <= HS_IDLE;
                    idle_ff <= 1'b1;
                    done_ff <= 1'b1;
                end
            end
            default: st_ff <= HS_IDLE;
            endcase
        end
    end
endmodule

//--- verification/odp_chk.sv
// Assertion checker watching the serial link between host end and flash end.
module odp_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic serial_input_line,
    input wire logic serial_output_line,
    input wire logic serial_output_line_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sck_idle_a: assert property (cs_n && $past(cs_n) |-> !sck)
        else $error("serial clock moves while deselected");
    frame_len_a: assert property ($fell(cs_n) |-> !cs_n [*8])
        else $error("select frame shorter than one bit time");
    sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("serial clock high phase not four cycles");
    sck_low_a: assert property ($fell(sck) |-> !sck [*4])
        else $error("serial clock low phase too short");
    mosi_hold_a: assert property (
        sck && $past(sck) |-> $stable(serial_input_line))
        else $error("input line changed while clock high");
    miso_fall_a: assert property (serial_output_line_oe
        && $past(serial_output_line_oe) && $changed(serial_output_line)
        |-> !sck)
        else $error("output line changed outside clock low phase");
    release_a: assert property (
        $rose(cs_n) |-> ##[1:6] !serial_output_line_oe)
        else $error("output line still driven after deselect");
    drive_sel_a: assert property ($rose(serial_output_line_oe) |-> !cs_n)
        else $error("output line driven while deselected");

    cover property ($rose(serial_output_line_oe));
    cover property (serial_output_line_oe && !serial_output_line);
    cover property ($rose(cs_n) && !sck);
endmodule

//--- verification/tb_otp_and_deep_powerdown_ctrl.sv
// Self-checking bench joining the host end and the flash end.
module tb_otp_and_deep_powerdown_ctrl;
    import odp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 20;
    localparam int PDLY = 200;
    logic clk = 0, resetn = 0, hw_reset_n = 1, prog_stall = 0, req = 0;
    logic [7:0] opcode = 8'h00, tx_data = 8'h00, rx_data;
    logic [5:0] tx_len = 6'h00, rx_len = 6'h00;
    logic tx_take, rx_valid, done, idle, powered_down, low_current, busy;
    logic [7:0] txb [0:67];
    logic [7:0] rxb [0:67];
    int n_errors = 0, check_count = 0;
    odp_spi_if spi();
    odp_flash #(.PROG_CYC(PDLY), .PROG_TIMEOUT(3 * PDLY), .DP_DELAY(DLY),
        .RDP_DELAY(DLY), .RST_DELAY(DLY)) odp_flash_inst (.clk(clk),
        .resetn(resetn), .clk_en(1'b1), .hw_reset_n(hw_reset_n),
        .prog_stall(prog_stall), .spi(spi), .powered_down(powered_down),
        .low_current(low_current), .busy(busy));
    odp_host odp_host_inst (.clk(clk), .resetn(resetn), .clk_en(1'b1),
        .req(req), .opcode(opcode), .tx_len(tx_len), .rx_len(rx_len),
        .tx_data(tx_data), .spi(spi), .tx_take(tx_take),
        .rx_valid(rx_valid), .rx_data(rx_data), .done(done), .idle(idle));
    odp_chk odp_chk_inst (.clk(clk), .resetn(resetn), .cs_n(spi.cs_n),
        .sck(spi.sck), .serial_input_line(spi.serial_input_line),
        .serial_output_line(spi.serial_output_line),
        .serial_output_line_oe(spi.serial_output_line_oe));
    always #5 clk = ~clk;

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Inputs change at the falling edge so the host samples them settled.
    task automatic frame(input logic [7:0] op, input int nt, input int nr);
        int i, k, w;
        i = 0;
        k = 0;
        w = 0;
        @(negedge clk);
        opcode = op;
        tx_len = nt[5:0];
        rx_len = nr[5:0];
        tx_data = txb[0];
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        while (!done && w < 20000) begin
            @(negedge clk);
            w++;
            if (tx_take && i < 67) begin
                i++;
                tx_data = txb[i];
            end
            if (rx_valid && k < 68) begin
                rxb[k] = rx_data;
                k++;
            end
        end
        chk("frame_done", {7'h00, done}, 8'h01);
        chk("host_idle", {7'h00, idle}, 8'h01);
        repeat (2) @(negedge clk);
    endtask
    task automatic addr(input logic [7:0] a);
        txb[0] = 8'h00;
        txb[1] = 8'h00;
        txb[2] = a;
        txb[3] = 8'h00;
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        addr(a);
        frame(OP_READ_OTP, 4, n);
    endtask
    task automatic prog(input logic [7:0] a, input logic [7:0] d);
        frame(OP_WREN, 0, 0);
        addr(a);
        txb[3] = d;
        frame(OP_PROG_OTP, 4, 0);
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int w;
        w = 0;
        while (s !== v && w < lim) begin
            @(negedge clk);
            w++;
        end
        chk("level_wait", {7'h00, s}, {7'h00, v});
    endtask
    task automatic regs(input logic [7:0] st, input logic [7:0] fl);
        frame(OP_RD_STATUS, 0, 1);
        chk("status", rxb[0] & 8'h03, st);
        frame(OP_RD_FLAG, 0, 1);
        chk("flags", rxb[0] & 8'h92, fl);
    endtask

    task automatic t_no_wren();
        addr(8'h00);
        txb[3] = 8'h5a;
        frame(OP_PROG_OTP, 4, 0);
        regs(8'h00, 8'h80);
        rd(8'h00, 1);
        chk("otp0", rxb[0], 8'hff);
    endtask
    task automatic t_prog_edge();
        frame(OP_WREN, 0, 0);
        addr(8'h3e);
        txb[3] = 8'ha5;
        txb[4] = 8'h3c;
        txb[5] = 8'hff;
        txb[6] = 8'h00;
        frame(OP_PROG_OTP, 7, 0);
        wait_lvl(busy, 1'b1, 8);
        chk("busy_on", {7'h00, busy}, 8'h01);
        frame(OP_RD_STATUS, 0, 1);
        chk("wip_bit", rxb[0] & 8'h01, 8'h01);
        wait_lvl(busy, 1'b0, 4 * PDLY);
        regs(8'h00, 8'h80);
        rd(8'h3e, 5);
        chk("otp3e", rxb[0], 8'ha5);
        chk("otp3f", rxb[1], 8'h3c);
        chk("ctrl", rxb[2], 8'hff);
        chk("stick", rxb[4], 8'hff);
        rd(8'h00, 1);
        chk("nowrap", rxb[0], 8'hff);
    endtask
    task automatic t_dpd();
        prog(8'h05, 8'h00);
        frame(OP_ENTER_DPD, 0, 0);
        chk("dpd_refused", {7'h00, powered_down}, 8'h00);
        wait_lvl(busy, 1'b0, 4 * PDLY);
        rd(8'h05, 1);
        chk("prog_kept", rxb[0], 8'h00);
        frame(OP_ENTER_DPD, 0, 0);
        wait_lvl(low_current, 1'b1, DLY + 8);
        chk("pd_on", {7'h00, powered_down}, 8'h01);
        frame(OP_WREN, 0, 0);
        frame(OP_RD_STATUS, 0, 1);
        chk("dpd_quiet", rxb[0], 8'hff);
        addr(8'h00);
        frame(OP_RELEASE_DPD, 1, 0);
        chk("void_rel", {7'h00, low_current}, 8'h01);
        frame(OP_RELEASE_DPD, 0, 0);
        wait_lvl(low_current, 1'b0, DLY + 8);
        repeat (DLY) @(negedge clk);
        regs(8'h00, 8'h80);
        frame(OP_ENTER_DPD, 0, 0);
        wait_lvl(low_current, 1'b1, DLY + 8);
        hw_reset_n = 1'b0;
        repeat (4) @(negedge clk);
        hw_reset_n = 1'b1;
        wait_lvl(low_current, 1'b0, DLY + 8);
        repeat (DLY + 4) @(negedge clk);
        frame(OP_ENTER_DPD, 0, 0);
        wait_lvl(low_current, 1'b1, DLY + 8);
        frame(OP_RST_EN, 0, 0);
        chk("rst_en_only", {7'h00, low_current}, 8'h01);
        frame(OP_RST, 0, 0);
        wait_lvl(low_current, 1'b0, DLY + 8);
        repeat (DLY + 4) @(negedge clk);
    endtask
    task automatic t_fail_lock();
        prog_stall = 1'b1;
        prog(8'h01, 8'h00);
        repeat (4 * PDLY) @(negedge clk);
        prog_stall = 1'b0;
        wait_lvl(busy, 1'b0, 4 * PDLY);
        regs(8'h00, 8'h90);
        prog(OTP_CTRL_ADDR, 8'hfe);
        wait_lvl(busy, 1'b0, 4 * PDLY);
        prog(8'h02, 8'h00);
        regs(8'h02, 8'h92);
        rd(8'h02, 1);
        chk("locked", rxb[0], 8'hff);
    endtask

    initial begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        t_no_wren();
        t_prog_edge();
        t_dpd();
        t_fail_lock();
        finish_test();
    end
    initial begin
        #300000;
        n_errors++;
        finish_test();
    end
endmodule
